// ---- rtl/smc_top.sv ----
// Purpose: Regulation style, hysteresis, stepping and loop settings of a
//          dual-output switching supply, with an Avalon-MM register slave
// Assumes: CLOCK is the converter reference clock; host mode is synchronous
// Notes:   The step-up strap is caught once after reset release
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"

// How it works
// [R1] Topology fixed until next power-up strap
// [R2] Continuous style keeps PWM always running
// [R3] Pulsed: burst below low, stop high
// [R4] Run, wait, stop use continuous only
// [R5] Very-low-power modes follow software selection
// [R6] Leakage stops force pulsed regulation
// [R7] Deepest stop: converter off, bypass only
// [R8] Hysteresis offsets -75..+75 mV, 25 mV
// [R9] Software avoids both offsets zero
// [R10] Startup loop hysteresis settings by software
// [R11] Step-up starts small limit; software writes 0x12
// [R12] Software enables differential comparators first
// [R13] Software disables stepping before pulsed
// [R14] Stepping moves targets 25 mV per step
// [R15] Pulsed only below 0.5 mA load
// [R16] Software rewrites input voltage when changed
// [R17] Regulation attempted at any input level
// [R18] Reset defaults 1.8/1.5 or 1.8/1.8
// [R19] Switching tick is reference divided 16
// [R20] Style selection applies at mode entry
module smc_top
  import smc_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [3:0]  POWER_MODE,
  input  wire logic        STRAP_STEPUP,
  input  wire logic        MAIN_BELOW_LOW,
  input  wire logic        MAIN_ABOVE_HIGH,
  output logic             PWM_ENABLE,
  output logic             PWM_TICK,
  output logic             PULSED_MODE,
  output logic             CONVERTER_ACTIVE,
  output logic             BYPASS_REQUIRED,
  output logic             STEPUP_MODE,
  output logic      [7:0]  MAIN_TARGET,
  output logic      [7:0]  RADIO_TARGET,
  output logic      [2:0]  HYST_LOW_OFFSET,
  output logic      [2:0]  HYST_HIGH_OFFSET,
  output logic             DIFF_CMP_SELECT,
  output logic      [1:0]  DIFF_HYST_THRESHOLD,
  output logic      [1:0]  COMMON_HYST_THRESHOLD,
  output logic             DIFF_HYST_ENABLE,
  output logic             COMMON_HYST_ENABLE,
  output logic             HYST_SIGN,
  output logic      [4:0]  CURRENT_LIMIT,
  output logic      [9:0]  INPUT_VOLTAGE
);

  smc_top_s   s_q;
  smc_top_s   s_d;
  smc_pmode_e pm;
  logic       req;
  logic       pm_rw;
  logic       prev_rw;
  logic       entry_rw;
  logic       entry_s;
  logic       burst;
  logic       busy_m;
  logic       busy_r;
  logic [7:0] rad_default;
  logic [31:0] bmask;
  logic [31:0] w_ctrl;
  logic [31:0] w_loop;
  logic [31:0] w_tgt;
  logic [31:0] w_vin;
  logic [31:0] w_stat;
  logic [31:0] rd_mux;
  logic [31:0] m_ctrl;
  logic [31:0] m_loop;
  logic [31:0] m_tgt;
  logic [31:0] m_vin;

  function automatic logic [2:0] sat_hyst(input logic [2:0] v);
    sat_hyst = (v > `SMC_HYST_MAX) ? `SMC_HYST_MAX : v;
  endfunction

  // ----------------------------------------
  // Register words
  // ----------------------------------------
  assign pm       = smc_pmode_e'(POWER_MODE);
  assign req      = AVS_READ | AVS_WRITE;
  assign bmask    = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                     {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign w_ctrl   = {23'h0, s_q.hyst_hi, s_q.hyst_lo, s_q.df_cmp, s_q.sel_s, s_q.sel_rw};
  assign w_loop   = {19'h0, s_q.ilim, 1'b0, s_q.sign, s_q.cm_en, s_q.df_en,
                     s_q.cm_thr, s_q.df_thr};
  assign w_tgt    = {14'h0, s_q.dis_radio, s_q.dis_main, s_q.tgt_radio, s_q.tgt_main};
  assign w_vin    = {22'h0, s_q.vin};
  assign w_stat   = {RADIO_TARGET, MAIN_TARGET, 4'h0, s_q.mode_prev, 2'b00, busy_r,
                     busy_m, CONVERTER_ACTIVE, burst, PULSED_MODE, s_q.stepup};
  assign m_ctrl   = (w_ctrl & ~bmask) | (AVS_WRITEDATA & bmask);
  assign m_loop   = (w_loop & ~bmask) | (AVS_WRITEDATA & bmask);
  assign m_tgt    = (w_tgt & ~bmask) | (AVS_WRITEDATA & bmask);
  assign m_vin    = (w_vin & ~bmask) | (AVS_WRITEDATA & bmask);

  always_comb
  begin
    case (AVS_ADDRESS)
      `SMC_ADDR_CTRL: rd_mux = w_ctrl;
      `SMC_ADDR_LOOP: rd_mux = w_loop;
      `SMC_ADDR_TGT:  rd_mux = w_tgt;
      `SMC_ADDR_VIN:  rd_mux = w_vin;
      `SMC_ADDR_STAT: rd_mux = w_stat;
      default:        rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Mode tracking
  // ----------------------------------------
  assign pm_rw       = (pm == SMC_PM_VL_RUN) || (pm == SMC_PM_VL_WAIT);
  assign prev_rw     = (s_q.mode_prev == SMC_PM_VL_RUN) || (s_q.mode_prev == SMC_PM_VL_WAIT);
  assign entry_rw    = pm_rw && !prev_rw;
  assign entry_s     = (pm == SMC_PM_VL_STOP) && (s_q.mode_prev != SMC_PM_VL_STOP);
  assign rad_default = STRAP_STEPUP ? `SMC_TGT_1V8 : `SMC_TGT_1V5;

  always_comb
  begin
    s_d       = s_q;
    s_d.ack   = req && !s_q.ack;
    s_d.div   = s_q.div + 4'h1;
    // [R19] Divide by 16
    s_d.tick  = (s_q.div == `SMC_DIV_LAST);
    s_d.mode_prev = pm;
    if (AVS_READ && !s_q.ack)
      s_d.rdata = rd_mux;
    // [R1] Strap caught once
    if (!s_q.strap_done)
    begin
      s_d.strap_done = 1'b1;
      s_d.stepup     = STRAP_STEPUP;
      // [R18] Power-up defaults
      s_d.tgt_main   = `SMC_TGT_1V8;
      s_d.tgt_radio  = rad_default;
    end
    else if (AVS_WRITE && s_q.ack)
    begin
      case (AVS_ADDRESS)
        `SMC_ADDR_CTRL:
        begin
          s_d.sel_rw  = m_ctrl[`SMC_CTRL_RWP];
          s_d.sel_s   = m_ctrl[`SMC_CTRL_SP];
          s_d.df_cmp  = m_ctrl[`SMC_CTRL_DCMP];
          // [R8] Offset range clamp
          s_d.hyst_lo = sat_hyst(m_ctrl[`SMC_CTRL_HLO +: 3]);
          s_d.hyst_hi = sat_hyst(m_ctrl[`SMC_CTRL_HHI +: 3]);
        end
        `SMC_ADDR_LOOP:
        begin
          s_d.df_thr = m_loop[`SMC_LOOP_DTH +: 2];
          s_d.cm_thr = m_loop[`SMC_LOOP_CTH +: 2];
          s_d.df_en  = m_loop[`SMC_LOOP_DEN];
          s_d.cm_en  = m_loop[`SMC_LOOP_CEN];
          s_d.sign   = m_loop[`SMC_LOOP_SGN];
          // [R11] Limit programmable after startup
          s_d.ilim   = m_loop[`SMC_LOOP_ILIM +: 5];
        end
        `SMC_ADDR_TGT:
        begin
          s_d.tgt_main  = m_tgt[`SMC_TGT_MAIN +: 8];
          s_d.tgt_radio = m_tgt[`SMC_TGT_RAD +: 8];
          s_d.dis_main  = m_tgt[`SMC_TGT_DISM];
          s_d.dis_radio = m_tgt[`SMC_TGT_DISR];
        end
        `SMC_ADDR_VIN: s_d.vin = m_vin[9:0];
        default:       s_d.vin = s_q.vin;
      endcase
    end
    // [R20] Selection latched on entry
    if (entry_rw)
      s_d.sel_lat = s_q.sel_rw;
    else if (entry_s)
      s_d.sel_lat = s_q.sel_s;
    // [R17] Input value never gates regulation
    case (pm)
      // [R4] Full power modes
      SMC_PM_RUN, SMC_PM_WAIT, SMC_PM_STOP:
        s_d.style = SMC_RS_CONT;
      // [R5] Software selected style
      SMC_PM_VL_RUN, SMC_PM_VL_WAIT:
        s_d.style = (entry_rw ? s_q.sel_rw : s_q.sel_lat) ? SMC_RS_PULSED : SMC_RS_CONT;
      SMC_PM_VL_STOP:
        s_d.style = (entry_s ? s_q.sel_s : s_q.sel_lat) ? SMC_RS_PULSED : SMC_RS_CONT;
      // [R6] Leakage stops
      SMC_PM_LL_STOP, SMC_PM_VLL_STOP:
        s_d.style = SMC_RS_PULSED;
      // [R7] Converter off
      SMC_PM_DEEP_STOP:
        s_d.style = SMC_RS_OFF;
      default:
        s_d.style = SMC_RS_CONT;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      s_q         <= '0;
      s_q.hyst_lo <= `SMC_HYST_LO_RST;
      s_q.hyst_hi <= `SMC_HYST_HI_RST;
      // [R11] Small startup limit
      s_q.ilim    <= `SMC_ILIM_STARTUP;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Rail stepping and bursts
  // ----------------------------------------
  smc_rail_stepper #(
    .RESET_LEVEL (`SMC_TGT_1V8)
  ) u_step_main (
    .clk      (CLOCK),
    .srst     (SRST),
    .load     (!s_q.strap_done),
    .load_val (`SMC_TGT_1V8),
    .target   (s_q.tgt_main),
    .step_dis (s_q.dis_main),
    .tick     (s_q.tick),
    .level    (MAIN_TARGET),
    .busy     (busy_m)
  );

  smc_rail_stepper #(
    .RESET_LEVEL (`SMC_TGT_1V5)
  ) u_step_radio (
    .clk      (CLOCK),
    .srst     (SRST),
    .load     (!s_q.strap_done),
    .load_val (rad_default),
    .target   (s_q.tgt_radio),
    .step_dis (s_q.dis_radio),
    .tick     (s_q.tick),
    .level    (RADIO_TARGET),
    .busy     (busy_r)
  );

  smc_burst_ctrl u_burst (
    .clk        (CLOCK),
    .srst       (SRST),
    .enable     (s_q.style == SMC_RS_PULSED),
    .below_low  (MAIN_BELOW_LOW),
    .above_high (MAIN_ABOVE_HIGH),
    .burst      (burst)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign AVS_READDATA    = s_q.rdata;
  assign AVS_WAITREQUEST = req && !s_q.ack;
  // [R2] Continuous keeps PWM on; pulsed follows burst
  assign PWM_ENABLE      = (s_q.style == SMC_RS_CONT) ||
                           ((s_q.style == SMC_RS_PULSED) && burst);
  assign PWM_TICK        = s_q.tick;
  assign PULSED_MODE     = (s_q.style == SMC_RS_PULSED);
  assign CONVERTER_ACTIVE = (s_q.style != SMC_RS_OFF);
  assign BYPASS_REQUIRED = (s_q.style == SMC_RS_OFF);
  assign STEPUP_MODE     = s_q.stepup;
  assign HYST_LOW_OFFSET = s_q.hyst_lo;
  assign HYST_HIGH_OFFSET = s_q.hyst_hi;
  assign DIFF_CMP_SELECT = s_q.df_cmp;
  assign DIFF_HYST_THRESHOLD   = s_q.df_thr;
  assign COMMON_HYST_THRESHOLD = s_q.cm_thr;
  assign DIFF_HYST_ENABLE      = s_q.df_en;
  assign COMMON_HYST_ENABLE    = s_q.cm_en;
  assign HYST_SIGN       = s_q.sign;
  assign CURRENT_LIMIT   = s_q.ilim;
  assign INPUT_VOLTAGE   = s_q.vin;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  sequence s_bus_req;
    req && AVS_WAITREQUEST;
  endsequence

  a_strap_fixed: assert property ( // [R1]
    (s_q.strap_done && $past(s_q.strap_done)) |-> $stable(STEPUP_MODE))
    else $error("topology changed while running");
  a_cont_pwm: assert property ( // [R2]
    (pm == SMC_PM_RUN) ##1 1'b1 |-> PWM_ENABLE && !PULSED_MODE)
    else $error("pwm not running in continuous style");
  a_full_cont: assert property ( // [R4]
    (pm == SMC_PM_WAIT || pm == SMC_PM_STOP) |=> !PULSED_MODE)
    else $error("pulsed style in full power mode");
  a_sel_entry: assert property ( // [R5]
    entry_rw |=> PULSED_MODE == $past(s_q.sel_rw))
    else $error("selection not applied on entry");
  a_sel_hold: assert property ( // [R20]
    (pm_rw && prev_rw && $past(pm_rw)) |=> $stable(PULSED_MODE))
    else $error("style changed inside a low power mode");
  a_leak_pulsed: assert property ( // [R6]
    (pm == SMC_PM_LL_STOP || pm == SMC_PM_VLL_STOP) |=> PULSED_MODE)
    else $error("leakage stop not pulsed");
  a_deep_off: assert property ( // [R7]
    (pm == SMC_PM_DEEP_STOP) |=> !CONVERTER_ACTIVE && BYPASS_REQUIRED && !PWM_ENABLE)
    else $error("converter active in deepest stop");
  a_hyst_range: assert property ( // [R8]
    HYST_LOW_OFFSET <= `SMC_HYST_MAX && HYST_HIGH_OFFSET <= `SMC_HYST_MAX)
    else $error("hysteresis code out of range");
  a_ilim_start: assert property ( // [R11]
    $rose(s_q.strap_done) |-> CURRENT_LIMIT == `SMC_ILIM_STARTUP)
    else $error("startup current limit wrong");
  a_defaults: assert property ( // [R18]
    $rose(s_q.strap_done) |-> MAIN_TARGET == `SMC_TGT_1V8 &&
      RADIO_TARGET == (STEPUP_MODE ? `SMC_TGT_1V8 : `SMC_TGT_1V5))
    else $error("power-up targets wrong");
  a_tick_period: assert property ( // [R19]
    PWM_TICK |=> (!PWM_TICK) [*8] ##1 (!PWM_TICK) [*7] ##1 PWM_TICK)
    else $error("switching tick not one in sixteen");
  a_bus_answer: assert property (
    s_bus_req |=> !AVS_WAITREQUEST)
    else $error("bus request not answered in one wait cycle");

endmodule

`default_nettype wire

// ---- rtl/smc_defs.svh ----
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: Byte addressed word registers on the register bus
// Notes:   Target codes are in 25 mV units; hysteresis code 3 means 0 mV
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SMC_ADDR_CTRL 5'h00
`define SMC_ADDR_LOOP 5'h04
`define SMC_ADDR_TGT  5'h08
`define SMC_ADDR_VIN  5'h0c
`define SMC_ADDR_STAT 5'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMC_CTRL_RWP  0
`define SMC_CTRL_SP   1
`define SMC_CTRL_DCMP 2
`define SMC_CTRL_HLO  3
`define SMC_CTRL_HHI  6
`define SMC_LOOP_DTH  0
`define SMC_LOOP_CTH  2
`define SMC_LOOP_DEN  4
`define SMC_LOOP_CEN  5
`define SMC_LOOP_SGN  6
`define SMC_LOOP_ILIM 8
`define SMC_TGT_MAIN  0
`define SMC_TGT_RAD   8
`define SMC_TGT_DISM  16
`define SMC_TGT_DISR  17
`define SMC_ST_STEPUP 0
`define SMC_ST_PULSED 1
`define SMC_ST_BURST  2
`define SMC_ST_ACTIVE 3
`define SMC_ST_BUSYM  4
`define SMC_ST_BUSYR  5
`define SMC_ST_MODE   8
`define SMC_ST_CURM   16
`define SMC_ST_CURR   24

// ----------------------------------------
// Values and counts
// ----------------------------------------
`define SMC_HYST_MAX     3'h6
`define SMC_HYST_LO_RST  3'h3
`define SMC_HYST_HI_RST  3'h6
`define SMC_ILIM_STARTUP 5'h04
`define SMC_TGT_1V8      8'h48
`define SMC_TGT_1V5      8'h3c
`define SMC_DIV_LAST     4'hf

`endif

// ---- rtl/smc_pkg.sv ----
// Purpose: Types shared by the switcher mode control modules
// Assumes: Host power mode arrives as a 4-bit code
// Notes:   Unknown mode codes are treated as full run
package smc_pkg;

  typedef enum logic [3:0] {
    SMC_PM_RUN       = 4'h0,
    SMC_PM_WAIT      = 4'h1,
    SMC_PM_STOP      = 4'h2,
    SMC_PM_VL_RUN    = 4'h3,
    SMC_PM_VL_WAIT   = 4'h4,
    SMC_PM_VL_STOP   = 4'h5,
    SMC_PM_LL_STOP   = 4'h6,
    SMC_PM_VLL_STOP  = 4'h7,
    SMC_PM_DEEP_STOP = 4'h8
  } smc_pmode_e;

  typedef enum logic [1:0] {
    SMC_RS_CONT   = 2'b00,
    SMC_RS_PULSED = 2'b01,
    SMC_RS_OFF    = 2'b10
  } smc_style_e;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        strap_done;
    logic        stepup;
    logic        sel_rw;
    logic        sel_s;
    logic        df_cmp;
    logic [2:0]  hyst_lo;
    logic [2:0]  hyst_hi;
    logic [1:0]  df_thr;
    logic [1:0]  cm_thr;
    logic        df_en;
    logic        cm_en;
    logic        sign;
    logic [4:0]  ilim;
    logic [7:0]  tgt_main;
    logic [7:0]  tgt_radio;
    logic        dis_main;
    logic        dis_radio;
    logic [9:0]  vin;
    smc_pmode_e  mode_prev;
    logic        sel_lat;
    smc_style_e  style;
    logic [3:0]  div;
    logic        tick;
  } smc_top_s;

  typedef struct packed {
    logic [7:0] level;
  } smc_step_s;

  typedef struct packed {
    logic burst;
  } smc_burst_s;

endpackage

// ---- rtl/smc_rail_stepper.sv ----
// Purpose: Ramps one rail's applied target toward the written target
// Assumes: tick is a one-cycle pulse at the switching rate
// Notes:   One step equals one 25 mV code
`timescale 1ns/1ps
`default_nettype none

module smc_rail_stepper
  import smc_pkg::*;
#(
  parameter logic [7:0] RESET_LEVEL = 8'h00
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic [7:0] target,
  input  wire logic       step_dis,
  input  wire logic       tick,
  output logic      [7:0] level,
  output logic            busy
);

  smc_step_s s_q;
  smc_step_s s_d;

  // [R14] Stepped approach
  always_comb
  begin
    s_d = s_q;
    if (load)
      s_d.level = load_val;
    else if (step_dis)
      s_d.level = target;
    else if (tick && (s_q.level < target))
      s_d.level = s_q.level + 8'h01;
    else if (tick && (s_q.level > target))
      s_d.level = s_q.level - 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s_q.level <= RESET_LEVEL;
    else
      s_q <= s_d;
  end

  assign level = s_q.level;
  assign busy  = (s_q.level != target);

  a_step_one: assert property (@(posedge clk) disable iff (srst) // [R14]
    (!load && !step_dis && tick && s_q.level < target) |=> level == $past(level) + 8'h01)
    else $error("stepper did not rise by one step");
  a_step_hold: assert property (@(posedge clk) disable iff (srst) // [R14]
    (!load && !step_dis && !tick) |=> $stable(level))
    else $error("stepper moved without a tick");

endmodule

`default_nettype wire

// ---- rtl/smc_burst_ctrl.sv ----
// Purpose: Starts and stops PWM bursts in pulsed regulation
// Assumes: Threshold comparators are synchronous levels
// Notes:   Reaching the upper threshold wins over the lower one
`timescale 1ns/1ps
`default_nettype none

module smc_burst_ctrl
  import smc_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic enable,
  input  wire logic below_low,
  input  wire logic above_high,
  output logic      burst
);

  smc_burst_s s_q;
  smc_burst_s s_d;

  // [R3] Burst hysteresis
  always_comb
  begin
    s_d = s_q;
    if (!enable || above_high)
      s_d.burst = 1'b0;
    else if (below_low)
      s_d.burst = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign burst = s_q.burst;

  sequence s_low_seen;
    enable && below_low && !above_high;
  endsequence

  a_burst_start: assert property (@(posedge clk) disable iff (srst) // [R3]
    s_low_seen |=> burst)
    else $error("burst not started below lower threshold");
  a_burst_stop: assert property (@(posedge clk) disable iff (srst) // [R3]
    (enable && above_high) |=> !burst)
    else $error("burst not stopped at upper threshold");

endmodule

`default_nettype wire

// ---- verification/smc_host_model.sv ----
// Purpose: Far-side model: host power-mode controller and main rail sensing
// Assumes: Mode requests come from the bench in the CLOCK domain
// Notes:   Rail is a crude integrator; threshold codes are arbitrary
`timescale 1ns/1ps
`default_nettype none

module smc_host_model
  import smc_pkg::*;
#(
  parameter int LOW_LVL  = 8,
  parameter int HIGH_LVL = 20
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] mode_req,
  input  wire logic       pwm_en,
  output logic      [3:0] power_mode,
  output logic            below_low,
  output logic            above_high
);
  logic [5:0] rail_q;

  always_ff @(posedge clk)
  begin
    power_mode <= mode_req;
    if (rst)
      rail_q <= 6'h00;
    else if (pwm_en && rail_q != 6'h3f)
      rail_q <= rail_q + 6'h01;
    else if (!pwm_en && rail_q != 6'h00)
      rail_q <= rail_q - 6'h01;
  end

  assign below_low  = rail_q < 6'(LOW_LVL);
  assign above_high = rail_q >= 6'(HIGH_LVL);
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the switcher mode control block
// Assumes: Bus waits on waitrequest; mode and rail come from the model
// Notes:   Byte enables stay all-on; partial lanes are not exercised
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
`define SMC_TB_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
  import smc_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_req;
  logic [3:0]  mode_req = 4'h0;
  logic [3:0]  pmode;
  logic        strap = 1'b0;
  logic        blo;
  logic        ahi;
  logic        pwm;
  logic        tick;
  logic        pulsed;
  logic        active;
  logic        bypass;
  logic        stepup;
  logic [7:0]  tmain;
  logic [7:0]  tradio;
  logic [2:0]  hlo;
  logic [2:0]  hhi;
  logic        dcmp;
  logic [1:0]  dthr;
  logic [1:0]  cthr;
  logic        den;
  logic        cen;
  logic        sgn;
  logic [4:0]  ilim;
  logic [9:0]  vin;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] rv;
  int          n;
  int          k;
  logic        seen;

  always #2.5 clk = ~clk;

  smc_top uut (.CLOCK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_req), .POWER_MODE(pmode), .STRAP_STEPUP(strap),
    .MAIN_BELOW_LOW(blo), .MAIN_ABOVE_HIGH(ahi), .PWM_ENABLE(pwm), .PWM_TICK(tick),
    .PULSED_MODE(pulsed), .CONVERTER_ACTIVE(active), .BYPASS_REQUIRED(bypass),
    .STEPUP_MODE(stepup), .MAIN_TARGET(tmain), .RADIO_TARGET(tradio),
    .HYST_LOW_OFFSET(hlo), .HYST_HIGH_OFFSET(hhi), .DIFF_CMP_SELECT(dcmp),
    .DIFF_HYST_THRESHOLD(dthr), .COMMON_HYST_THRESHOLD(cthr), .DIFF_HYST_ENABLE(den),
    .COMMON_HYST_ENABLE(cen), .HYST_SIGN(sgn), .CURRENT_LIMIT(ilim), .INPUT_VOLTAGE(vin));

  smc_host_model host (.clk(clk), .rst(srst), .mode_req(mode_req), .pwm_en(pwm),
    .power_mode(pmode), .below_low(blo), .above_high(ahi));

  // ----------------------------------------
  // Bus and mode tasks
  // ----------------------------------------
  task automatic bus_xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    begin
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do
      begin
        @(posedge clk);
      end while (wait_req !== 1'b0);
      rv = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic set_mode(input int m);
    begin
      mode_req <= 4'(m);
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic do_reset();
    begin
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  function automatic logic [2:0] sat(input int v);
    return (v > 6) ? 3'h6 : 3'(v);
  endfunction

  function automatic logic exp_pulsed(input int m, input logic s);
    return (m >= 3 && m <= 5) ? s : (m == 6 || m == 7);
  endfunction

  task automatic final_report();
    begin
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    bus_xfer(1'b0, `SMC_ADDR_STAT, 32'h0);
    `SMC_TB_CHK(rv, 32'h3c480008)
    bus_xfer(1'b0, `SMC_ADDR_LOOP, 32'h0);
    `SMC_TB_CHK(rv, 32'h00000400)
    bus_xfer(1'b0, 5'h14, 32'h0);
    `SMC_TB_CHK(rv, 32'h0)
    bus_xfer(1'b1, `SMC_ADDR_LOOP, 32'h00001270);
    bus_xfer(1'b0, `SMC_ADDR_LOOP, 32'h0);
    `SMC_TB_CHK(rv, 32'h00001270)
    `SMC_TB_CHK({den, cen, sgn, dthr, cthr, ilim}, {3'b111, 4'h0, 5'h12})
    // k and k^1 differ, so both offsets never sit at 0 mV
    for (k = 0; k < 8; k++)
    begin
      bus_xfer(1'b1, `SMC_ADDR_CTRL, {23'h0, 3'(k ^ 1), 3'(k), 3'b100});
      `SMC_TB_CHK({hlo, hhi}, {sat(k), sat(k ^ 1)})
    end
    bus_xfer(1'b1, `SMC_ADDR_VIN, 32'h000002a5);
    `SMC_TB_CHK(vin, 10'h2a5)
    bus_xfer(1'b1, `SMC_ADDR_VIN, 32'h0);
    `SMC_TB_CHK(active, 1'b1)
    bus_xfer(1'b1, `SMC_ADDR_TGT, 32'h00003c4a);
    `SMC_TB_CHK(tmain === 8'h4a, 1'b0)
    seen = 1'b0;
    n = 0;
    while (tmain !== 8'h4a && n < 60)
    begin
      seen = seen | (tmain === 8'h49);
      @(posedge clk);
      n++;
    end
    `SMC_TB_CHK({seen, tmain}, {1'b1, 8'h4a})
    bus_xfer(1'b1, `SMC_ADDR_TGT, 32'h00033c50);
    @(posedge clk);
    `SMC_TB_CHK(tmain, 8'h50)
    n = 0;
    while (tick !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 40);
    `SMC_TB_CHK(n, 16)
    for (k = 0; k < 2; k++)
    begin
      bus_xfer(1'b1, `SMC_ADDR_CTRL, {23'h0, 3'h6, 3'h3, 1'b1, 1'(k), 1'(k)});
      `SMC_TB_CHK(dcmp, 1'b1)
      for (n = 0; n < 10; n++)
      begin
        set_mode(0);
        set_mode(n);
        `SMC_TB_CHK({pulsed, bypass, active}, {exp_pulsed(n, 1'(k)), n == 8, n != 8})
      end
    end
    set_mode(0);
    n = 0;
    repeat (100)
    begin
      @(posedge clk);
      n += (pwm !== 1'b1);
    end
    `SMC_TB_CHK(n, 0)
    set_mode(3);
    bus_xfer(1'b1, `SMC_ADDR_CTRL, 32'h00000184);
    set_mode(4);
    `SMC_TB_CHK(pulsed, 1'b1)
    set_mode(0);
    set_mode(3);
    `SMC_TB_CHK(pulsed, 1'b0)
    set_mode(6);
    n = 0;
    k = 0;
    repeat (300)
    begin
      @(posedge clk);
      n += (pwm === 1'b1 && !seen);
      k += (pwm === 1'b0 && seen);
      seen = pwm;
    end
    `SMC_TB_CHK({n > 2, k > 2}, 2'b11)
    set_mode(8);
    `SMC_TB_CHK({pwm, bypass}, 2'b01)
    set_mode(0);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    `SMC_TB_CHK(stepup, 1'b0)
    do_reset();
    `SMC_TB_CHK({stepup, tmain, tradio, ilim}, {1'b1, 8'h48, 8'h48, 5'h04})
    final_report();
  end
endmodule

`default_nettype wire
